// ---- twm_master.sv ----
/*
  Two-wire bus master transmitter with an Avalon-MM register port.
  Software issues START, repeated START and STOP through two_wire_control,
  loads bytes into two_wire_data and reads a status code after each event.
  Assumes open-drain bus wires resolved outside (oe high pulls the wire low),
  and that the bus wires come from outside the clock domain.
*/
`default_nettype none

// Functional notes
// - start request waits for idle bus, then START
// - START sent sets flag, status 0x08
// - address byte done sets flag, 0x18/0x20/0x38
// - 0x18 address acked, 0x20 address not acked
// - 0x28 data acked, 0x30 data not acked
// - data write with flag low dropped, collision set
// - load byte and clear flag transmits it
// - stop request sends STOP, stop bit self-clears
// - start request in transmitter gives repeated START, 0x10
// - after 0x10 read address switches to receiver
// - start plus stop sends STOP then START
// - 0x38 with start low releases bus
// - 0x38 with start high waits, then START
// - transfer stalls, clock held low, while flag set, except after 0x38 when the clock is released
module twm_master
  import twm_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // two-wire bus
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // system
  output logic             irq,
  output logic             receiver_mode
);

  twm_state_t         state;
  logic [7:0]         control;
  logic [7:0]         data;
  logic [7:0]         status;
  logic [7:0]         shift;
  logic [EVENT_W-1:0] events;
  logic [EVENT_W-1:0] mask;
  logic [EVENT_W-1:0] new_events;
  logic [1:0]         phase;
  logic [3:0]         bit_cnt;
  logic               ack_q;
  logic               req;
  logic               take;
  logic               wr_ctl;
  logic               wr_data;
  logic               wr_mask;
  logic               rd_event;
  logic               scl_s;
  logic               sda_s;
  logic               scl_d;
  logic               sda_d;
  logic               bus_busy;
  logic               tick;
  logic               drive_scl;
  logic               drive_sda;
  logic               owner;
  logic               addr_phase;
  logic               rw_bit;
  logic               ack_ok;
  logic               flag_set;
  logic               stop_done;
  logic               arb_ev;
  logic               enabled;
  logic               flag;

  assign enabled = control[CB_ENABLE];
  assign flag    = control[CB_FLAG];

  // bus slave: one wait state per access
  assign req         = read | write;
  assign waitrequest = req & ~ack_q;
  assign take        = req & ack_q;
  assign wr_ctl      = take & write & byteenable[0] & (address == OFS_CONTROL);
  assign wr_data     = take & write & byteenable[0] & (address == OFS_DATA);
  assign wr_mask     = take & write & byteenable[0] & (address == OFS_MASK);
  assign rd_event    = take & read & (address == OFS_EVENT);

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (req & ~ack_q) begin
      case (address)
        OFS_CONTROL: readdata <= {24'h000000, control};
        OFS_STATUS:  readdata <= {24'h000000, status[7:3], 3'h0};
        OFS_DATA:    readdata <= {24'h000000, data};
        OFS_EVENT:   readdata <= {{(32 - EVENT_W){1'b0}}, events};
        OFS_MASK:    readdata <= {{(32 - EVENT_W){1'b0}}, mask};
        default:     readdata <= 32'h00000000;
      endcase
    end
  end

  // control: write-one clears flag, hardware set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      control <= CONTROL_RESET;
    end else begin
      if (wr_ctl) begin
        control[CB_ACK_EN] <= writedata[CB_ACK_EN];
        control[CB_START]  <= writedata[CB_START];
        control[CB_STOP]   <= writedata[CB_STOP];
        control[CB_ENABLE] <= writedata[CB_ENABLE];
        control[CB_IE]     <= writedata[CB_IE];
        if (writedata[CB_FLAG]) begin
          control[CB_FLAG] <= 1'b0;
        end
      end
      if (wr_data) begin
        control[CB_WC] <= ~flag;
      end
      if (stop_done) begin
        control[CB_STOP] <= 1'b0;
      end
      if (flag_set) begin
        control[CB_FLAG] <= 1'b1;
      end
    end
  end

  // data register accepts writes only while flag is high
  always_ff @(posedge clk) begin
    if (reset) begin
      data <= DATA_RESET;
    end else if (wr_data && flag) begin
      data <= writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= writedata[EVENT_W-1:0];
    end
  end

  // sticky events; a read clears only bits it returned
  assign new_events = {stop_done, arb_ev, wr_data & ~flag, flag_set};

  always_ff @(posedge clk) begin
    if (reset) begin
      events <= '0;
    end else if (rd_event) begin
      events <= (events & ~readdata[EVENT_W-1:0]) | new_events;
    end else begin
      events <= events | new_events;
    end
  end

  assign irq = (|(events & mask)) | (flag & control[CB_IE]);

  // bus wires and idle tracking
  twm_sync #(
    .WIDTH       (2),
    .RESET_VALUE (2'h3)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({scl_in, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_busy <= 1'b0;
    end else if (scl_s && scl_d && sda_d && !sda_s) begin
      bus_busy <= 1'b1;
    end else if (scl_s && scl_d && !sda_d && sda_s) begin
      bus_busy <= 1'b0;
    end
  end

  twm_tick #(
    .COUNT (QUARTER)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .run   (enabled),
    .tick  (tick)
  );

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = drive_scl;
  assign sda_oe  = drive_sda;

  // bus sequencer, four quarter-bit phases per bit
  always_ff @(posedge clk) begin
    if (reset || !enabled) begin
      state         <= S_IDLE;
      phase         <= 2'h0;
      bit_cnt       <= 4'h0;
      shift         <= DATA_RESET;
      drive_scl     <= 1'b0;
      drive_sda     <= 1'b0;
      status        <= ST_IDLE;
      owner         <= 1'b0;
      addr_phase    <= 1'b0;
      rw_bit        <= 1'b0;
      ack_ok        <= 1'b0;
      receiver_mode <= 1'b0;
      flag_set      <= 1'b0;
      stop_done     <= 1'b0;
      arb_ev        <= 1'b0;
    end else begin
      flag_set  <= 1'b0;
      stop_done <= 1'b0;
      arb_ev    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (control[CB_START] && !flag && !flag_set) begin
            state <= S_WAIT_FREE;
          end
        end
        S_WAIT_FREE: begin
          if (!bus_busy && tick) begin
            state <= S_START;
            phase <= 2'h0;
          end
        end
        S_START: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                drive_sda <= 1'b0;
                phase     <= 2'h1;
              end
              2'h1: begin
                drive_scl <= 1'b0;
                if (scl_s) begin
                  phase <= 2'h2;
                end
              end
              2'h2: begin
                drive_sda <= 1'b1;
                phase     <= 2'h3;
              end
              default: begin
                drive_scl <= 1'b1;
                status    <= owner ? ST_RESTART : ST_START;
                owner     <= 1'b1;
                flag_set  <= 1'b1;
                state     <= S_HOLD;
                phase     <= 2'h0;
              end
            endcase
          end
        end
        S_HOLD: begin
          // clock stays low until software clears the flag, except after arbitration loss (0x38), when it is released
          if (!flag && !flag_set) begin
            if (status == ST_ARB_LOST) begin
              owner <= 1'b0;
              state <= control[CB_START] ? S_WAIT_FREE : S_IDLE;
            end else if (control[CB_STOP]) begin
              state <= S_STOP;
              phase <= 2'h0;
            end else if (control[CB_START]) begin
              state <= S_START;
              phase <= 2'h0;
            end else begin
              shift      <= data;
              rw_bit     <= data[0];
              addr_phase <= (status == ST_START) || (status == ST_RESTART);
              bit_cnt    <= 4'h0;
              phase      <= 2'h0;
              state      <= S_BYTE;
            end
          end
        end
        S_BYTE: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                drive_sda <= (bit_cnt == ACK_BIT_INDEX) ? 1'b0 : ~shift[7];
                phase     <= 2'h1;
              end
              2'h1: begin
                drive_scl <= 1'b0;
                if (scl_s) begin
                  phase <= 2'h2;
                end
              end
              2'h2: begin
                if (bit_cnt == ACK_BIT_INDEX) begin
                  ack_ok <= ~sda_s;
                  phase  <= 2'h3;
                end else if (!drive_sda && !sda_s) begin
                  // another master drove low: back off the bus
                  drive_sda <= 1'b0;
                  owner     <= 1'b0;
                  status    <= ST_ARB_LOST;
                  flag_set  <= 1'b1;
                  arb_ev    <= 1'b1;
                  state     <= S_HOLD;
                  phase     <= 2'h0;
                end else begin
                  phase <= 2'h3;
                end
              end
              default: begin
                drive_scl <= 1'b1;
                phase     <= 2'h0;
                if (bit_cnt == ACK_BIT_INDEX) begin
                  if (addr_phase && rw_bit) begin
                    status        <= ack_ok ? ST_RADDR_ACK : ST_RADDR_NACK;
                    receiver_mode <= 1'b1;
                  end else if (addr_phase) begin
                    status <= ack_ok ? ST_ADDR_ACK : ST_ADDR_NACK;
                  end else begin
                    status <= ack_ok ? ST_DATA_ACK : ST_DATA_NACK;
                  end
                  flag_set <= 1'b1;
                  state    <= S_HOLD;
                end else begin
                  shift   <= {shift[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
                end
              end
            endcase
          end
        end
        S_STOP: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                drive_sda <= 1'b1;
                phase     <= 2'h1;
              end
              2'h1: begin
                drive_scl <= 1'b0;
                if (scl_s) begin
                  phase <= 2'h2;
                end
              end
              2'h2: begin
                drive_sda <= 1'b0;
                phase     <= 2'h3;
              end
              default: begin
                stop_done     <= 1'b1;
                owner         <= 1'b0;
                receiver_mode <= 1'b0;
                status        <= ST_IDLE;
                phase         <= 2'h0;
                state         <= control[CB_START] ? S_WAIT_FREE : S_IDLE;
              end
            endcase
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_start_request: assert property (
    (state == S_IDLE && enabled && control[CB_START] && !flag && !flag_set) |=> state == S_WAIT_FREE)
    else $error("start request not taken");

  a_start_code: assert property (
    (state == S_START && enabled && tick && phase == 2'h3 && !owner) |=> (status == ST_START && flag_set)
    ##1 flag)
    else $error("start did not report 0x08 and set flag");

  a_restart_code: assert property (
    (state == S_START && enabled && tick && phase == 2'h3 && owner) |=> (status == ST_RESTART && owner))
    else $error("repeated start did not report 0x10");

  a_addr_codes: assert property (
    (state == S_BYTE && enabled && tick && phase == 2'h3 && bit_cnt == ACK_BIT_INDEX && addr_phase && !rw_bit)
    |=> (status == (ack_ok ? ST_ADDR_ACK : ST_ADDR_NACK)) ##1 flag)
    else $error("address byte status wrong");

  a_data_codes: assert property (
    (state == S_BYTE && enabled && tick && phase == 2'h3 && bit_cnt == ACK_BIT_INDEX && !addr_phase)
    |=> status == (ack_ok ? ST_DATA_ACK : ST_DATA_NACK))
    else $error("data byte status wrong");

  a_read_switch: assert property (
    (state == S_BYTE && enabled && tick && phase == 2'h3 && bit_cnt == ACK_BIT_INDEX && addr_phase && rw_bit)
    |=> receiver_mode)
    else $error("read address did not switch to receiver");

  a_collision_bit: assert property (
    (wr_data && !flag && !flag_set) |=> (control[CB_WC] && data == $past(data) && events[EV_COLLISION]))
    else $error("write with flag low not discarded");

  a_load_byte: assert property (
    (state == S_HOLD && enabled && !flag && !flag_set && status == ST_DATA_ACK
     && !control[CB_START] && !control[CB_STOP]) |=> (state == S_BYTE && shift == $past(data)))
    else $error("loaded byte not sent");

  a_stop_clears: assert property (
    (state == S_STOP && enabled && tick && phase == 2'h3) |=> stop_done ##1 !control[CB_STOP])
    else $error("stop bit not cleared after stop");

  a_stop_start: assert property (
    (state == S_STOP && enabled && tick && phase == 2'h3 && control[CB_START]) |=> state == S_WAIT_FREE)
    else $error("stop then start not followed");

  a_hold_clock: assert property (
    (state == S_HOLD && status != ST_ARB_LOST) |-> drive_scl)
    else $error("clock released while suspended");

  a_arb_release: assert property (
    (state == S_HOLD && status == ST_ARB_LOST) |-> (!drive_scl && !drive_sda && !owner))
    else $error("bus not released after arbitration loss");

  a_wait_free: assert property (
    (state == S_WAIT_FREE && enabled && bus_busy) |=> state == S_WAIT_FREE)
    else $error("start attempted on busy bus");

  a_irq_level: assert property (
    (flag && control[CB_IE]) |-> irq)
    else $error("interrupt missing with flag set");

  c_data_ack: cover property (state == S_HOLD && status == ST_DATA_ACK);
  c_arb_lost: cover property (state == S_HOLD && status == ST_ARB_LOST);
  c_restart:  cover property (state == S_HOLD && status == ST_RESTART);
  c_stop:     cover property (stop_done);

endmodule

`default_nettype wire

// ---- twm_pkg.sv ----
/*
  Shared constants for the two-wire master transmitter: register offsets,
  control bit positions, status codes, event bits, timing and the state type.
  Assumes a 50 MHz system clock and a byte-addressed Avalon-MM register port.
*/
`default_nettype none

package twm_pkg;

  // timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int SCL_HZ         = 100_000;
  localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);

  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS  = 5'h04;
  localparam logic [4:0] OFS_DATA    = 5'h08;
  localparam logic [4:0] OFS_EVENT   = 5'h0C;
  localparam logic [4:0] OFS_MASK    = 5'h10;

  // two_wire_control bit positions
  localparam int CB_FLAG   = 7;
  localparam int CB_ACK_EN = 6;
  localparam int CB_START  = 5;
  localparam int CB_STOP   = 4;
  localparam int CB_WC     = 3;
  localparam int CB_ENABLE = 2;
  localparam int CB_IE     = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'hFF;
  localparam logic [3:0] MASK_RESET    = 4'h0;

  // event register bits
  localparam int EVENT_W      = 4;
  localparam int EV_FLAG      = 0;
  localparam int EV_COLLISION = 1;
  localparam int EV_ARB       = 2;
  localparam int EV_STOP      = 3;

  // status codes, low three bits zero
  localparam logic [7:0] ST_START      = 8'h08;
  localparam logic [7:0] ST_RESTART    = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK   = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK  = 8'h20;
  localparam logic [7:0] ST_DATA_ACK   = 8'h28;
  localparam logic [7:0] ST_DATA_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST   = 8'h38;
  localparam logic [7:0] ST_RADDR_ACK  = 8'h40;
  localparam logic [7:0] ST_RADDR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE       = 8'hF8;

  localparam logic [3:0] ACK_BIT_INDEX = 4'h8;

  typedef enum logic [5:0] {
    S_IDLE      = 6'b000001,
    S_WAIT_FREE = 6'b000010,
    S_START     = 6'b000100,
    S_BYTE      = 6'b001000,
    S_HOLD      = 6'b010000,
    S_STOP      = 6'b100000
  } twm_state_t;

endpackage

`default_nettype wire

// ---- twm_sync.sv ----
/*
  Two-flop synchroniser for a group of asynchronous input levels.
  Assumes the inputs are quasi-static compared with the clock.
*/
`default_nettype none

module twm_sync #(
  parameter int               WIDTH       = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          meta[i]     <= RESET_VALUE[i];
          sync_out[i] <= RESET_VALUE[i];
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- twm_tick.sv ----
/*
  Divider giving a one-cycle enable pulse every COUNT clocks while run is high.
  Assumes COUNT of at least one.
*/
`default_nettype none

module twm_tick #(
  parameter int COUNT = 125
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == CW'(COUNT - 1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- twm_slave.sv ----
/*
  Behavioural slave receiver on the two-wire bus, with an optional rival
  master that holds the data wire low to win arbitration.
  Assumes resolved wire levels from the bench.
*/
`default_nettype none

module twm_slave (
  // bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour
  input  wire logic       ack_on,
  input  wire logic       rival,
  output logic            sda_oe,
  output logic      [7:0] last_byte,
  output logic      [7:0] stops
);
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       active;

  initial begin
    sda_oe = 1'b0;
    bit_cnt = 4'h0;
    shift = 8'h00;
    active = 1'b0;
    last_byte = 8'h00;
    stops = 8'h00;
  end

  // start and stop seen while the clock wire is high
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    bit_cnt = 4'h0;
  end
  always @(posedge sda) if (scl) begin
    active = 1'b0;
    stops = stops + 8'h01;
  end

  // msb first, ninth clock is the acknowledge slot
  always @(posedge scl) if (active) begin
    if (bit_cnt < 4'h8) begin
      shift = {shift[6:0], sda};
      bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'h8) last_byte = shift;
    end else begin
      bit_cnt = 4'h9;
    end
  end

  always @(negedge scl) if (active) begin
    if (bit_cnt == 4'h0 && rival) sda_oe = 1'b1;
    else if (bit_cnt == 4'h8) sda_oe = ack_on;
    else if (bit_cnt == 4'h9) begin
      sda_oe = 1'b0;
      bit_cnt = 4'h0;
    end
  end

  // rival grabs the data wire while the clock is held low
  always @(posedge rival) sda_oe = 1'b1;

  // rival lets go, giving a stop on the idle clock
  always @(negedge rival) sda_oe = 1'b0;
endmodule

`default_nettype wire

// ---- twm_master_tb.sv ----
/*
  Self-checking bench for the two-wire master transmitter.
  Assumes open-drain wires with pull-ups resolved here and QUARTER of 2.
*/
`default_nettype none

module twm_master_tb
  import twm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic        ack_on = 1'b1, rival = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, scl_oe, sda_oe, slv_oe, irq, scl, sda, rmode;
  logic [7:0]  last_byte, stops, v, n;
  int          miscompares = 0, checks = 0;

  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | slv_oe);
  always #10 clk = ~clk;

  twm_master #(.QUARTER(2)) u_dut (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .irq(irq), .receiver_mode(rmode));
  twm_slave u_slave (.scl(scl), .sda(sda), .ack_on(ack_on), .rival(rival), .sda_oe(slv_oe),
    .last_byte(last_byte), .stops(stops));

  task results;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= rd;
    write <= ~rd;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    v = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wait_irq;
    int k;
    k = 0;
    // let the flag clear land before looking for the next interrupt
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 3000);
    check("irq", {7'h0, irq}, 8'h01);
  endtask

  task go(input logic [7:0] ctl, input logic [7:0] exp);
    bus(1'b0, OFS_CONTROL, ctl);
    wait_irq;
    bus(1'b1, OFS_STATUS, 8'h00);
    check("status", v & 8'hF8, exp);
  endtask

  task send(input logic [7:0] d, input logic [7:0] exp);
    bus(1'b0, OFS_DATA, d);
    go(8'h85, exp);
  endtask

  task t_regs;
    bus(1'b1, OFS_CONTROL, 8'h00); check("control", v, CONTROL_RESET);
    bus(1'b1, OFS_STATUS, 8'h00); check("status", v, ST_IDLE);
    bus(1'b1, OFS_DATA, 8'h00); check("data", v, DATA_RESET);
    bus(1'b1, OFS_MASK, 8'h00); check("mask", v, {4'h0, MASK_RESET});
    bus(1'b1, 5'h14, 8'h00); check("unmapped", v, 8'h00);
  endtask

  task t_collision;
    bus(1'b0, OFS_DATA, 8'h5A);
    bus(1'b1, OFS_DATA, 8'h00); check("data kept", v, DATA_RESET);
    bus(1'b1, OFS_CONTROL, 8'h00); check("collision", {7'h0, v[CB_WC]}, 8'h01);
    bus(1'b0, OFS_MASK, 8'h02);
    @(posedge clk); check("irq on", {7'h0, irq}, 8'h01);
    bus(1'b1, OFS_EVENT, 8'h00); check("event", v, 8'h02);
    @(posedge clk); check("irq off", {7'h0, irq}, 8'h00);
    bus(1'b0, OFS_MASK, 8'h00);
  endtask

  task t_transfer;
    go(8'hA5, ST_START);
    repeat (50) @(posedge clk); check("stall", {7'h0, scl_oe}, 8'h01);
    send(8'hA0, ST_ADDR_ACK); check("addr", last_byte, 8'hA0);
    send(8'h3C, ST_DATA_ACK); check("byte", last_byte, 8'h3C);
    ack_on <= 1'b0;
    send(8'h55, ST_DATA_NACK);
    go(8'hA5, ST_RESTART);
    send(8'hA0, ST_ADDR_NACK);
    ack_on <= 1'b1;
    go(8'hA5, ST_RESTART);
    send(8'hA1, ST_RADDR_ACK); check("receiver", {7'h0, rmode}, 8'h01);
    n = stops;
    go(8'hB5, ST_START); check("stop count", stops, n + 8'h01);
    check("receiver off", {7'h0, rmode}, 8'h00);
    bus(1'b1, OFS_CONTROL, 8'h00); check("stop bit", {7'h0, v[CB_STOP]}, 8'h00);
  endtask

  task t_arb;
    int k;
    rival <= 1'b1;
    send(8'hA0, ST_ARB_LOST);
    check("released", {6'h0, scl_oe, sda_oe}, 8'h00);
    bus(1'b0, OFS_CONTROL, 8'hA5);
    repeat (100) @(posedge clk);
    check("waits", {7'h0, irq}, 8'h00);
    rival <= 1'b0;
    wait_irq;
    bus(1'b1, OFS_STATUS, 8'h00); check("status", v, ST_START);
    n = stops;
    bus(1'b0, OFS_CONTROL, 8'h95);
    k = 0;
    do begin
      bus(1'b1, OFS_CONTROL, 8'h00);
      k++;
    end while (v[CB_STOP] !== 1'b0 && k < 100);
    check("stop bit", {7'h0, v[CB_STOP]}, 8'h00);
    check("stop count", stops, n + 8'h01);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_collision;
    t_transfer;
    t_arb;
    results;
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    results;
  end
endmodule

`default_nettype wire
